// >>> dv/frs_drive_model.sv
`timescale 1ns/1ps

// Far side: fault detectors and power stage
module frs_drive_model (
    // Clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // Bench requests
    input wire logic fire_i,
    input wire frs_pkg::frs_fault_t code_i,
    // Block side
    input wire frs_pkg::frs_restart_t restart_i,
    output frs_pkg::frs_trip_t trip_o,
    output logic [7:0] restarts_o
);
    // One-cycle trip; idle code keeps changing so a stale code is never trusted
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            trip_o <= '0;
        end else begin
            trip_o.valid <= fire_i;
            trip_o.code <= fire_i ? code_i : frs_pkg::frs_fault_t'(~trip_o.code);
        end
    end
    // Power stage counts restarts
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            restarts_o <= 8'h00;
        end else if (restart_i.valid) begin
            restarts_o <= restarts_o + 8'h01;
        end
    end
endmodule

// >>> dv/testbench.sv
`timescale 1ns/1ps

module testbench;
    logic clock, arst_n, wr, rd, fire, pe_on, fault, freset, excess, active, irq;
    logic [5:0] addr;
    logic [31:0] wdata, rdata, v;
    logic [3:0] first;
    logic [7:0] restarts;
    frs_pkg::frs_fault_t code;
    frs_pkg::frs_trip_t trip;
    frs_pkg::frs_restart_t restart;
    int err_count, comparisons, cycles;

    // ****************************************
    // Harness
    // ****************************************
    frs_top #(.TICK_CYCLES(2)) i_dut (.clock_i(clock), .arst_n_i(arst_n),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .trip_i(trip), .pe_at_power_on_i(pe_on), .fault_o(fault),
        .fault_reset_o(freset), .restart_o(restart), .retry_excess_o(excess),
        .retry_active_o(active), .first_fault_o(first), .irq_o(irq));
    frs_drive_model i_drive (.clock_i(clock), .arst_n_i(arst_n), .fire_i(fire),
        .code_i(code), .restart_i(restart), .trip_o(trip), .restarts_o(restarts));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Hang guard, far above the longest expected run
    always @(posedge clock) begin
        cycles++;
        if (cycles == 8000) begin
            err_count++;
            report_and_stop();
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
        #1;
    endtask

    // Read data only stands in the cycle after the strobe
    task automatic rd_reg(input logic [5:0] a, output logic [31:0] d);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // Ends once the block has taken the trip and updated its outputs
    task automatic do_trip(input frs_pkg::frs_fault_t c);
        @(posedge clock);
        fire <= 1'b1;
        code <= c;
        @(posedge clock);
        fire <= 1'b0;
        @(posedge clock);
        #1;
    endtask

    task automatic wait_restart();
        for (int i = 0; i < 40 && restart.valid !== 1'b1; i++) begin
            @(posedge clock);
            #1;
        end
        chk("restart", 1, restart.valid);
        chk("fault_reset", 1, freset);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        rd_reg(6'h00, v); chk("select", 0, v);
        rd_reg(6'h04, v); chk("limit", 0, v);
        rd_reg(6'h08, v); chk("wait", 'h0a, v);
        rd_reg(6'h0c, v); chk("success", 0, v);
        rd_reg(6'h3c, v); chk("unmapped", 0, v);
        chk("flying", 0, restart.flying);
        wr_reg(6'h10, 32'h00000005);
        @(posedge clock);
        #1 chk("flying", 1, restart.flying);
        wr_reg(6'h14, 32'h000000a4);
        @(posedge clock);
        #1 chk("active_low", 1, active);
        wr_reg(6'h14, 32'h00000040);
    endtask

    task automatic t_success();
        wr_reg(6'h04, 32'h00000003);
        wr_reg(6'h08, 32'h00000001);
        do_trip(frs_pkg::F_OV_DECEL);
        chk("active", 1, active);
        chk("fault", 0, fault);
        wait_restart();
        do_trip(frs_pkg::F_OC_ACCEL);
        rd_reg(6'h18, v); chk("fails", 1, v[7:4]);
        wait_restart();
        repeat (8) @(posedge clock);
        rd_reg(6'h0c, v); chk("early", 0, v);
        repeat (20) @(posedge clock);
        rd_reg(6'h0c, v); chk("success", 1, v);
        rd_reg(6'h18, v); chk("status", 0, v[7:0]);
        chk("first", 5, first);
        wr_reg(6'h0c, 32'h00000000);
        rd_reg(6'h0c, v); chk("cleared", 0, v);
    endtask

    task automatic t_fail();
        logic [7:0] r0;
        r0 = restarts;
        wr_reg(6'h04, 32'h00000002);
        do_trip(frs_pkg::F_OC_CONST);
        wait_restart();
        do_trip(frs_pkg::F_OC_CONST);
        wait_restart();
        do_trip(frs_pkg::F_OC_CONST);
        @(posedge clock);
        #1 chk("excess", 1, excess);
        chk("fault", 1, fault);
        chk("restarts", 32'(r0) + 32'h2, restarts);
        wr_reg(6'h28, 32'h00000001);
        @(posedge clock);
        #1 chk("excess", 0, excess);
        wr_reg(6'h04, 32'h00000000);
        do_trip(frs_pkg::F_OC_ACCEL);
        chk("active", 0, active);
        chk("halt", 1, fault);
        wr_reg(6'h28, 32'h00000001);
    endtask

    task automatic t_loud();
        wr_reg(6'h04, 32'h00000065);
        do_trip(frs_pkg::F_GROUND);
        chk("fault", 1, fault);
        chk("active", 1, active);
        wait_restart();
        chk("fault", 0, fault);
        repeat (20) @(posedge clock);
    endtask

    task automatic t_select();
        logic [2:0] sel [7] = '{3'h1, 3'h2, 3'h4, 3'h4, 3'h5, 3'h3, 3'h0};
        frs_pkg::frs_fault_t f [7] = '{frs_pkg::F_OV_ACCEL, frs_pkg::F_OV_CONST,
            frs_pkg::F_STALL, frs_pkg::F_PTC, frs_pkg::F_OC_CONST,
            frs_pkg::F_OC_ACCEL, frs_pkg::F_EXT_THERM};
        logic go [7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
        wr_reg(6'h20, 32'h00000001);
        for (int i = 0; i < 7; i++) begin
            wr_reg(6'h00, {29'h0, sel[i]});
            do_trip(f[i]);
            chk("retry", go[i], active);
            @(posedge clock);
            #1 chk("irq", 1, irq);
            if (go[i]) begin
                wait_restart();
                repeat (20) @(posedge clock);
            end else begin
                wr_reg(6'h28, 32'h00000001);
            end
            wr_reg(6'h24, 32'h0000000f);
            @(posedge clock);
            #1 chk("irq_clear", 0, irq);
        end
        @(posedge clock);
        pe_on <= 1'b1;
        do_trip(frs_pkg::F_PARAM_STORE);
        chk("pe_power_on", 0, active);
        rd_reg(6'h1c, v); chk("irq_stat", 1, v[0]);
        wr_reg(6'h20, 32'h00000000);
        @(posedge clock);
        #1 chk("irq_mask", 0, irq);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        {arst_n, wr, rd, fire, pe_on} = 5'h00;
        addr = 6'h00;
        wdata = 32'h00000000;
        code = frs_pkg::F_OC_ACCEL;
        repeat (10) @(posedge clock);
        arst_n <= 1'b1;
        t_reset();
        t_success();
        t_fail();
        t_loud();
        t_select();
        report_and_stop();
    end
endmodule

// >>> inc/frs_defs.svh
// What this block does
// (R1) Retry count limit zero disables automatic retry entirely.
// (R2) Limits 1 to 10 give that many retries; fault output quiet while retrying.
// (R3) Limits 101 to 110 give setting minus 100 retries; fault output raised.
// (R4) Wait time spans 0.1 to 600 s, default 1 s, from trip to retry.
// (R5) After the wait, clear the fault and restart from starting frequency.
// (R6) Consecutive failures reaching the limit raise retry-excess fault and stop retrying.
// (R7) Fault-free run over four wait times after restart counts one success.
// (R8) A successful retry clears the consecutive failure count.
// (R9) Reading the success counter returns the cumulative successful restarts.
// (R10) Writing zero to the success counter clears it.
// (R11) Retry-active flag high during retry; code 64 active high, 164 active low.
// (R12) Fault selection 0 to 5, default 0; unselected faults never retry.
// (R13) Selection 0 all, 1 overcurrent, 2 overvoltage, 3 both groups.
// (R14) Selection 4 the wider group list; selection 5 first and third overcurrent.
// (R15) Coasting time other than 9999 selects the power-failure restart procedure.
// (R16) A parameter storage fault at power-on is never retried.
// (R17) Only the first fault of a retry sequence is recorded.
// (R18) Retry reset keeps thermal and regeneration duty data, unlike power-on reset.
// (R19) Each trip before a retry is judged successful counts one failure.
`ifndef FRS_DEFS_SVH
`define FRS_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define FRS_A_SELECT 6'h00
`define FRS_A_LIMIT 6'h04
`define FRS_A_WAIT 6'h08
`define FRS_A_SUCCESS 6'h0c
`define FRS_A_COAST 6'h10
`define FRS_A_TERMINAL 6'h14
`define FRS_A_STATUS 6'h18
`define FRS_A_IRQ_STAT 6'h1c
`define FRS_A_IRQ_EN 6'h20
`define FRS_A_IRQ_CLR 6'h24
`define FRS_A_COMMAND 6'h28

// ****************************************
// Values and limits
// ****************************************
`define FRS_SELECT_DEF 3'h0
`define FRS_SELECT_MAX 3'h5
`define FRS_LIMIT_DEF 7'h00
`define FRS_LIMIT_QUIET_MAX 7'h0a
`define FRS_LIMIT_LOUD_MIN 7'h65
`define FRS_LIMIT_LOUD_MAX 7'h6e
`define FRS_LIMIT_OFFSET 7'h64
`define FRS_WAIT_DEF 13'h000a
`define FRS_WAIT_MIN 13'h0001
`define FRS_WAIT_MAX 13'h1770
`define FRS_COAST_OFF 14'h270f
`define FRS_COAST_DEF 14'h270f
`define FRS_TERM_HIGH 8'h40
`define FRS_TERM_LOW 8'ha4
`define FRS_JUDGE_SHIFT 2
`define FRS_SUCCESS_MAX 16'hffff

// ****************************************
// Selection masks, bit index is fault code
// ****************************************
`define FRS_MASK_ALL 16'hffff
`define FRS_MASK_OC 16'h0007
`define FRS_MASK_OV 16'h0038
`define FRS_MASK_OCOV 16'h003f
`define FRS_MASK_WIDE 16'hf33f
`define FRS_MASK_OC13 16'h0005

// ****************************************
// Interrupt bits and command fields
// ****************************************
`define FRS_IRQ_TRIP 0
`define FRS_IRQ_RETRY 1
`define FRS_IRQ_SUCCESS 2
`define FRS_IRQ_EXCESS 3
`define FRS_CMD_RESET 0

// ****************************************
// Timing: one wait step is 0.1 s
// ****************************************
`define FRS_WAIT_UNIT_NS 100000000
`define FRS_CLK_PERIOD_NS 10
`define FRS_TICK_CYCLES (`FRS_WAIT_UNIT_NS / `FRS_CLK_PERIOD_NS)

`endif

// >>> inc/frs_pkg.sv
package frs_pkg;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_WAIT = 2'b01,
        ST_JUDGE = 2'b10,
        ST_HALT = 2'b11
    } frs_state_t;

    // Fault classes reported by the detectors
    typedef enum logic [3:0] {
        F_OC_ACCEL = 4'h0,
        F_OC_CONST = 4'h1,
        F_OC_DECEL = 4'h2,
        F_OV_ACCEL = 4'h3,
        F_OV_CONST = 4'h4,
        F_OV_DECEL = 4'h5,
        F_THERM_MOTOR = 4'h6,
        F_THERM_TRANS = 4'h7,
        F_BRAKE = 4'h8,
        F_GROUND = 4'h9,
        F_EXT_THERM = 4'ha,
        F_PTC = 4'hb,
        F_STALL = 4'hc,
        F_PARAM_STORE = 4'hd,
        F_IN_PHASE = 4'he,
        F_OUT_CURRENT = 4'hf
    } frs_fault_t;

    // Trip report from the fault detectors
    typedef struct packed {
        logic valid;
        frs_fault_t code;
    } frs_trip_t;

    // Restart command toward the power stage
    typedef struct packed {
        logic valid;
        logic flying;
    } frs_restart_t;

endpackage

// >>> rtl/frs_top.sv
`timescale 1ns/1ps
`include "frs_defs.svh"

module frs_top #(
    parameter int unsigned TICK_CYCLES = `FRS_TICK_CYCLES
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // Register port
    input wire logic [5:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // Fault detectors
    input wire frs_pkg::frs_trip_t trip_i,
    input wire logic pe_at_power_on_i,
    // Power stage
    output logic fault_o,
    output logic fault_reset_o,
    output frs_pkg::frs_restart_t restart_o,
    output logic retry_excess_o,
    output logic retry_active_o,
    output logic [3:0] first_fault_o,
    output logic irq_o
);

    // ****************************************
    // Helper functions
    // ****************************************

    // Retries allowed by a limit setting
    function automatic logic [3:0] frs_allowed(input logic [6:0] lim);
        if (lim >= 7'h01 && lim <= `FRS_LIMIT_QUIET_MAX) begin
            return lim[3:0]; // R2
        end else if (lim >= `FRS_LIMIT_LOUD_MIN && lim <= `FRS_LIMIT_LOUD_MAX) begin
            return 4'(lim - `FRS_LIMIT_OFFSET); // R3
        end else begin
            return 4'h0; // R1
        end
    endfunction

    // Fault class eligible under a selection
    function automatic logic frs_eligible(input logic [2:0] sel, input logic [3:0] code);
        logic [15:0] mask;
        case (sel)
            3'h0: mask = `FRS_MASK_ALL; // R13
            3'h1: mask = `FRS_MASK_OC; // R13
            3'h2: mask = `FRS_MASK_OV; // R13
            3'h3: mask = `FRS_MASK_OCOV; // R13
            3'h4: mask = `FRS_MASK_WIDE; // R14
            3'h5: mask = `FRS_MASK_OC13; // R14
            default: mask = 16'h0000;
        endcase
        return mask[code]; // R12
    endfunction

    // Limit setting values that the block accepts
    function automatic logic frs_limit_ok(input logic [31:0] v);
        return v[31:7] == 25'h0 && (v[6:0] <= `FRS_LIMIT_QUIET_MAX ||
            (v[6:0] >= `FRS_LIMIT_LOUD_MIN && v[6:0] <= `FRS_LIMIT_LOUD_MAX));
    endfunction

    // ****************************************
    // Declarations
    // ****************************************
    frs_pkg::frs_state_t state_q, state_d;
    logic [2:0] select_q;
    logic [6:0] limit_q;
    logic [12:0] wait_q;
    logic [13:0] coast_q;
    logic pol_low_q;
    logic [15:0] success_q;
    logic [3:0] fail_q, fail_d;
    logic [23:0] tick_cnt_q;
    logic [14:0] timer_q;
    logic [3:0] irq_stat_q, irq_stat_d, irq_en_q, ev;
    logic first_valid_q, excess_q;
    logic tick, timer_done, wr_hit_cmd, cmd_reset, loud, retryable;
    logic [3:0] allowed;
    logic [14:0] judge_lim;
    logic [31:0] rd_mux;

    // ****************************************
    // Shared decode
    // ****************************************

    // Settings decoded for the sequencer
    assign allowed = frs_allowed(limit_q);
    assign loud = limit_q >= `FRS_LIMIT_LOUD_MIN; // R3
    assign judge_lim = {wait_q, 2'b00} >> (2 - `FRS_JUDGE_SHIFT); // R7
    assign wr_hit_cmd = wr_i && addr_i == `FRS_A_COMMAND;
    assign cmd_reset = wr_hit_cmd && wdata_i[`FRS_CMD_RESET];
    // A storage fault seen at power-on is excluded outright
    assign retryable = allowed != 4'h0 && frs_eligible(select_q, trip_i.code) &&
        !(trip_i.code == frs_pkg::F_PARAM_STORE && pe_at_power_on_i); // R1 R12 R16

    // ****************************************
    // Timebase
    // ****************************************

    // 0.1 s tick, restarted on each state change so waits are exact
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tick_cnt_q <= 24'h0;
        end else if (state_d != state_q || tick) begin
            tick_cnt_q <= 24'h0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 24'h1;
        end
    end
    assign tick = tick_cnt_q == 24'(TICK_CYCLES - 1);

    // Elapsed ticks in the current state
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            timer_q <= 15'h0;
        end else if (state_d != state_q) begin
            timer_q <= 15'h0;
        end else if (tick) begin
            timer_q <= timer_q + 15'h1;
        end
    end

    // Greater-or-equal so a shortened setting cannot strand the wait
    always_comb begin
        timer_done = 1'b0;
        if (tick && state_q == frs_pkg::ST_WAIT) begin
            timer_done = 15'(timer_q + 15'h1) >= 15'(wait_q); // R4
        end else if (tick && state_q == frs_pkg::ST_JUDGE) begin
            timer_done = timer_q >= judge_lim; // R7
        end
    end

    // ****************************************
    // Retry sequencer
    // ****************************************

    // Next state, failure count and events
    always_comb begin
        state_d = state_q;
        fail_d = fail_q;
        ev = 4'h0;
        case (state_q)
            frs_pkg::ST_RUN: begin
                if (trip_i.valid) begin
                    ev[`FRS_IRQ_TRIP] = 1'b1;
                    fail_d = 4'h0;
                    state_d = retryable ? frs_pkg::ST_WAIT : frs_pkg::ST_HALT; // R1
                end
            end
            frs_pkg::ST_WAIT: begin
                if (timer_done) begin
                    ev[`FRS_IRQ_RETRY] = 1'b1; // R5
                    state_d = frs_pkg::ST_JUDGE;
                end
            end
            frs_pkg::ST_JUDGE: begin
                if (trip_i.valid) begin
                    ev[`FRS_IRQ_TRIP] = 1'b1;
                    fail_d = fail_q + 4'h1; // R19
                    if (!retryable) begin
                        state_d = frs_pkg::ST_HALT;
                    end else if (fail_d >= allowed) begin
                        ev[`FRS_IRQ_EXCESS] = 1'b1; // R6
                        state_d = frs_pkg::ST_HALT;
                    end else begin
                        state_d = frs_pkg::ST_WAIT;
                    end
                end else if (timer_done) begin
                    ev[`FRS_IRQ_SUCCESS] = 1'b1; // R7
                    fail_d = 4'h0; // R8
                    state_d = frs_pkg::ST_RUN;
                end
            end
            frs_pkg::ST_HALT: begin
                if (cmd_reset) begin
                    fail_d = 4'h0;
                    state_d = frs_pkg::ST_RUN;
                end
            end
            default: begin
                state_d = frs_pkg::ST_RUN;
            end
        endcase
    end

    // Sequencer state
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= frs_pkg::ST_RUN;
            fail_q <= 4'h0;
        end else begin
            state_q <= state_d;
            fail_q <= fail_d;
        end
    end

    // First fault of a sequence only; later trips leave it alone
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            first_fault_o <= 4'h0;
            first_valid_q <= 1'b0;
        end else if (state_q == frs_pkg::ST_RUN && trip_i.valid) begin
            first_fault_o <= trip_i.code; // R17
            first_valid_q <= 1'b1;
        end
    end

    // Excess fault stands until software resets the drive
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            excess_q <= 1'b0;
        end else if (ev[`FRS_IRQ_EXCESS]) begin
            excess_q <= 1'b1; // R6
        end else if (cmd_reset) begin
            excess_q <= 1'b0;
        end
    end
    assign retry_excess_o = excess_q;

    // ****************************************
    // Drive outputs
    // ****************************************

    // Fault, flag and restart command, all registered
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fault_o <= 1'b0;
            retry_active_o <= 1'b0;
            fault_reset_o <= 1'b0;
            restart_o <= '0;
        end else begin
            fault_o <= state_d == frs_pkg::ST_HALT ||
                (state_d == frs_pkg::ST_WAIT && loud); // R2 R3
            retry_active_o <= (state_d == frs_pkg::ST_WAIT) ^ pol_low_q; // R11
            // Soft reset: the stage keeps thermal and duty history
            fault_reset_o <= ev[`FRS_IRQ_RETRY]; // R5 R18
            restart_o.valid <= ev[`FRS_IRQ_RETRY]; // R5
            restart_o.flying <= coast_q != `FRS_COAST_OFF; // R15
        end
    end

    // ****************************************
    // Settings registers
    // ****************************************

    // Out-of-range select, limit, wait and terminal writes are dropped; coast and interrupt enable writes are taken unchecked
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            select_q <= `FRS_SELECT_DEF;
            limit_q <= `FRS_LIMIT_DEF;
            wait_q <= `FRS_WAIT_DEF;
            coast_q <= `FRS_COAST_DEF;
            pol_low_q <= 1'b0;
            irq_en_q <= 4'h0;
        end else if (wr_i) begin
            case (addr_i)
                `FRS_A_SELECT: begin
                    if (wdata_i <= 32'(`FRS_SELECT_MAX)) begin
                        select_q <= wdata_i[2:0]; // R12
                    end
                end
                `FRS_A_LIMIT: begin
                    if (frs_limit_ok(wdata_i)) begin
                        limit_q <= wdata_i[6:0];
                    end
                end
                `FRS_A_WAIT: begin
                    if (wdata_i >= 32'(`FRS_WAIT_MIN) && wdata_i <= 32'(`FRS_WAIT_MAX)) begin
                        wait_q <= wdata_i[12:0]; // R4
                    end
                end
                `FRS_A_COAST: coast_q <= wdata_i[13:0];
                `FRS_A_TERMINAL: begin
                    if (wdata_i == 32'(`FRS_TERM_HIGH)) begin
                        pol_low_q <= 1'b0; // R11
                    end else if (wdata_i == 32'(`FRS_TERM_LOW)) begin
                        pol_low_q <= 1'b1; // R11
                    end
                end
                `FRS_A_IRQ_EN: irq_en_q <= wdata_i[3:0];
                default: begin
                end
            endcase
        end
    end

    // Success counter saturates; a success beside a clear still counts
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            success_q <= 16'h0;
        end else if (wr_i && addr_i == `FRS_A_SUCCESS && wdata_i == 32'h0) begin
            success_q <= {15'h0, ev[`FRS_IRQ_SUCCESS]}; // R10
        end else if (ev[`FRS_IRQ_SUCCESS] && success_q != `FRS_SUCCESS_MAX) begin
            success_q <= success_q + 16'h1; // R7
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************

    // Sticky status, set wins over clear
    always_comb begin
        irq_stat_d = irq_stat_q;
        if (wr_i && addr_i == `FRS_A_IRQ_CLR) begin
            irq_stat_d = irq_stat_q & ~wdata_i[3:0];
        end
        irq_stat_d = irq_stat_d | ev;
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_stat_q <= 4'h0;
            irq_o <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq_o <= |(irq_stat_d & irq_en_q);
        end
    end

    // ****************************************
    // Read port
    // ****************************************

    // Read data stand only in the cycle after the strobe
    always_comb begin
        case (addr_i)
            `FRS_A_SELECT: rd_mux = {29'h0, select_q};
            `FRS_A_LIMIT: rd_mux = {25'h0, limit_q};
            `FRS_A_WAIT: rd_mux = {19'h0, wait_q};
            `FRS_A_SUCCESS: rd_mux = {16'h0, success_q}; // R9
            `FRS_A_COAST: rd_mux = {18'h0, coast_q};
            `FRS_A_TERMINAL: rd_mux = pol_low_q ? 32'(`FRS_TERM_LOW) : 32'(`FRS_TERM_HIGH);
            `FRS_A_STATUS: rd_mux = {19'h0, first_valid_q, first_fault_o, fail_q,
                excess_q, 1'b0, state_q};
            `FRS_A_IRQ_STAT: rd_mux = {28'h0, irq_stat_q};
            `FRS_A_IRQ_EN: rd_mux = {28'h0, irq_en_q};
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= 32'h0;
        end else begin
            rdata_o <= rd_i ? rd_mux : 32'h0;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_restart_cmd;
        restart_o.valid && fault_reset_o && !fault_o;
    endsequence

    sequence s_trip_judge;
        state_q == frs_pkg::ST_JUDGE && trip_i.valid && retryable;
    endsequence

    a_zero_no_retry: assert property ( // R1
        limit_q == 7'h0 && state_q == frs_pkg::ST_RUN && trip_i.valid
        |=> state_q == frs_pkg::ST_HALT ##1 fault_o)
        else $error("retry started with limit zero");
    a_quiet_fault_out: assert property ( // R2
        state_q == frs_pkg::ST_WAIT && $past(state_q) == frs_pkg::ST_WAIT && !loud
        |-> !fault_o)
        else $error("fault output raised during quiet retry");
    a_loud_fault_out: assert property ( // R3
        state_q == frs_pkg::ST_WAIT && loud |=> fault_o || state_q != frs_pkg::ST_WAIT)
        else $error("fault output missing during loud retry");
    a_wait_restart: assert property ( // R5
        state_q == frs_pkg::ST_WAIT && timer_done |=> s_restart_cmd)
        else $error("restart not issued after wait");
    a_wait_not_early: assert property ( // R4
        state_q == frs_pkg::ST_WAIT && 15'(timer_q + 15'h1) < 15'(wait_q)
        |=> !restart_o.valid)
        else $error("restart issued before wait elapsed");
    a_excess_trip: assert property ( // R6
        s_trip_judge and 4'(fail_q + 4'h1) >= allowed
        |=> state_q == frs_pkg::ST_HALT ##1 retry_excess_o && fault_o)
        else $error("retry excess not raised");
    a_success_count: assert property ( // R7
        state_q == frs_pkg::ST_JUDGE && timer_done && !trip_i.valid && !wr_i
        && success_q != `FRS_SUCCESS_MAX |=> success_q == $past(success_q) + 16'h1)
        else $error("success counter did not step");
    a_success_clear_fail: assert property ( // R8
        ev[`FRS_IRQ_SUCCESS] |=> fail_q == 4'h0 && state_q == frs_pkg::ST_RUN)
        else $error("failure count kept after success");
    a_success_read: assert property ( // R9
        rd_i && addr_i == `FRS_A_SUCCESS |=> rdata_o == {16'h0, $past(success_q)})
        else $error("success counter read wrong");
    a_success_erase: assert property ( // R10
        wr_i && addr_i == `FRS_A_SUCCESS && wdata_i == 32'h0 && !ev[`FRS_IRQ_SUCCESS]
        |=> success_q == 16'h0)
        else $error("success counter not cleared");
    a_flag_polarity: assert property ( // R11
        retry_active_o == ((state_q == frs_pkg::ST_WAIT) ^ pol_low_q)
        || $changed(pol_low_q))
        else $error("retry flag level wrong");
    a_select_gate: assert property ( // R12
        state_q == frs_pkg::ST_RUN && trip_i.valid && !frs_eligible(select_q, trip_i.code)
        |=> state_q == frs_pkg::ST_HALT)
        else $error("unselected fault retried");
    a_pe_power_on: assert property ( // R16
        state_q != frs_pkg::ST_HALT && trip_i.valid && pe_at_power_on_i
        && trip_i.code == frs_pkg::F_PARAM_STORE && state_q != frs_pkg::ST_WAIT
        |=> state_q == frs_pkg::ST_HALT)
        else $error("power-on storage fault retried");
    a_first_fault_hold: assert property ( // R17
        state_q != frs_pkg::ST_RUN |=> $stable(first_fault_o))
        else $error("first fault overwritten");
    a_fail_step: assert property ( // R19
        s_trip_judge |=> fail_q == 4'($past(fail_q) + 4'h1))
        else $error("failure not counted");

endmodule
